// ---- bench/dff_host_model.sv ----
// serial control host driving write frames on the three-wire port
`timescale 1ns/1ps
`default_nettype none
module dff_host_model (
    // clock
    input wire logic i_clk,
    // serial control pins
    output logic o_csb,
    output logic o_sclk,
    output logic o_sdin
);
    initial
    begin
        o_csb = 1'b1;
        o_sclk = 1'b0;
        o_sdin = 1'b0;
    end
    // n low bits of w, msb first; idle data shows the inverse bit
    task automatic send(input logic [23:0] w, input int n);
        o_csb = 1'b0;
        repeat (3) @(negedge i_clk);
        for (int i = n - 1; i >= 0; i--)
        begin
            o_sdin = w[i];
            repeat (3) @(negedge i_clk);
            o_sclk = 1'b1;
            repeat (3) @(negedge i_clk);
            o_sclk = 1'b0;
        end
        repeat (3) @(negedge i_clk);
        o_csb = 1'b1;
        o_sdin = ~o_sdin;
        repeat (8) @(negedge i_clk);
    endtask : send
endmodule : dff_host_model
`default_nettype wire

// ---- bench/dff_regs_monitor.sv ----
// assertion checker for the register bank decoded outputs
`timescale 1ns/1ps
`default_nettype none
module dff_regs_monitor (
    // clock, reset and zero detect
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_zero_detect_raw,
    // format outputs
    input wire logic [1:0] o_input_word_length,
    input wire logic [5:0] o_word_length_bits,
    input wire logic [1:0] o_framing_format,
    // filter outputs
    input wire logic [2:0] o_oversampling_filter_select,
    input wire logic [2:0] o_oversampling_response,
    input wire logic [1:0] o_bitstream_comp_filter_select,
    input wire logic [2:0] o_bitstream_comp_response,
    input wire logic [1:0] o_deemphasis_select,
    input wire logic o_deemphasis_enable,
    input wire logic [15:0] o_deemphasis_rate_hz,
    input wire logic o_zero_output_force_high,
    input wire logic o_zero_detect_output,
    // mode outputs
    input wire logic [1:0] o_operating_mode_select,
    input wire logic o_mode_pcm,
    input wire logic o_mode_bitstream_direct,
    input wire logic o_mode_bitstream_converted,
    input wire logic [2:0] o_clock_ratio_select,
    input wire logic o_clock_ratio_auto,
    input wire logic [9:0] o_clock_ratio_fs,
    input wire logic o_soft_reset
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [5:0] wl(input logic [1:0] c);
        return (c == 2'h3) ? 6'h20 : 6'h10 + {2'h0, c, 2'h0};
    endfunction : wl
    function automatic logic [15:0] dr(input logic [1:0] c);
        return c[1] ? (c[0] ? 16'hbb80 : 16'hac44)
            : (c[0] ? 16'h7d00 : 16'h0);
    endfunction : dr
    function automatic logic [9:0] fs(input logic [2:0] c);
        case (c)
            3'h1: return 10'h080;
            3'h2: return 10'h0c0;
            3'h3: return 10'h100;
            3'h4: return 10'h180;
            3'h5: return 10'h200;
            3'h6: return 10'h300;
            default: return 10'h000;
        endcase
    endfunction : fs
    property p_wl;
        o_word_length_bits == wl($past(o_input_word_length));
    endproperty
    a_wl: assert property (p_wl) else $error("word length");
    property p_resp;
        o_oversampling_response ==
            (($past(o_oversampling_filter_select) > 3'h4)
            ? 3'h0 : $past(o_oversampling_filter_select) + 3'h1);
    endproperty
    a_resp: assert property (p_resp) else $error("filter response");
    property p_comp;
        o_bitstream_comp_response
            == {1'b0, $past(o_bitstream_comp_filter_select)} + 3'h1;
    endproperty
    a_comp: assert property (p_comp) else $error("comp response");
    property p_deemphasis_select;
        o_deemphasis_rate_hz == dr($past(o_deemphasis_select))
            && o_deemphasis_enable == ($past(o_deemphasis_select) != 2'h0);
    endproperty
    a_deemphasis_select: assert property (p_deemphasis_select) else $error("deemphasis");
    // first edge after release still shows the reset value
    property p_zero;
        $past(i_resetn) |-> o_zero_detect_output
            == ($past(o_zero_output_force_high) | $past(i_zero_detect_raw));
    endproperty
    a_zero: assert property (p_zero) else $error("zero output");
    property p_mode;
        {o_mode_pcm, o_mode_bitstream_direct, o_mode_bitstream_converted}
            == (3'h4 >> $past(o_operating_mode_select));
    endproperty
    a_mode: assert property (p_mode) else $error("mode decode");
    property p_ratio;
        o_clock_ratio_fs == fs($past(o_clock_ratio_select))
            && o_clock_ratio_auto == ($past(o_clock_ratio_select) == 3'h0);
    endproperty
    a_ratio: assert property (p_ratio) else $error("ratio decode");
    property p_soft;
        o_soft_reset |-> o_input_word_length == 2'h2 && o_framing_format == 2'h2
            && o_oversampling_filter_select == 3'h0 && o_clock_ratio_select == 3'h0
            && !o_zero_output_force_high ##1 !o_soft_reset;
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset");
    c_soft: cover property (o_soft_reset);
    c_force: cover property (o_zero_output_force_high && !i_zero_detect_raw);
    c_conv: cover property (o_mode_bitstream_converted);
endmodule : dff_regs_monitor
bind dff_regs dff_regs_monitor u_mon (.*);
`default_nettype wire

// ---- bench/test_dff_regs.sv ----
// self-checking bench for the format, filter and mode register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
    $display("FAIL %0t got %h exp %h", $time, a, e); end end
module test_dff_regs;
    logic i_clk, i_resetn, i_software_mode, i_zero_detect_raw;
    logic i_ctrl_csb, i_ctrl_sclk, i_ctrl_sdin;
    logic [1:0] i_rate_band_pin, o_input_word_length, o_framing_format;
    logic [1:0] o_bitstream_comp_filter_select, o_deemphasis_select;
    logic [1:0] o_operating_mode_select, o_rate_band_select;
    logic [1:0] o_rate_band_effective;
    logic [2:0] o_oversampling_filter_select, o_oversampling_response;
    logic [2:0] o_bitstream_comp_response, o_clock_ratio_select;
    logic [5:0] o_word_length_bits;
    logic [9:0] o_clock_ratio_fs;
    logic [15:0] o_deemphasis_rate_hz;
    logic o_frame_clock_polarity, o_frame_clock_invert, o_dsp_variant_b;
    logic o_bit_clock_polarity, o_output_phase_invert, o_power_down_select;
    logic o_deemphasis_enable, o_zero_output_force_high, o_zero_detect_output;
    logic o_mode_pcm, o_mode_bitstream_direct, o_mode_bitstream_converted;
    logic o_clock_ratio_auto, o_filter_bypass_eight_times, o_soft_reset;
    logic [7:0] fmt_m, flt_m, mode_m, rnd, zs, d8;
    int fails, compares, pulses;
    dff_regs dut (.*);
    dff_host_model host (.i_clk, .o_csb(i_ctrl_csb), .o_sclk(i_ctrl_sclk),
        .o_sdin(i_ctrl_sdin));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    function automatic logic [5:0] wlb(input logic [1:0] c);
        case (c)
            2'h0: return 6'h10;
            2'h1: return 6'h14;
            2'h2: return 6'h18;
            default: return 6'h20;
        endcase
    endfunction : wlb
    // host keeps unused mode, ratio and band codes out
    function automatic logic [7:0] legal(input logic [7:0] d);
        if (d[1:0] == 2'h3) d[1:0] = 2'h0;
        if (d[4:2] == 3'h7) d[4:2] = 3'h6;
        if (d[6:5] == 2'h3) d[6:5] = 2'h1;
        return d;
    endfunction : legal
    task automatic defaults;
        fmt_m = 8'h0a;
        flt_m = 8'h00;
        mode_m = 8'h00;
    endtask : defaults
    task automatic wr(input logic [23:0] w, input int n);
        host.send(w, n);
        if (n >= 16)
        begin
            case (w[15:9])
                7'h05: fmt_m = w[7:0];
                7'h06: flt_m = w[7:0];
                7'h07: mode_m = w[7:0];
                7'h09: defaults();
                default: ;
            endcase
        end
    endtask : wr
    task automatic check;
        `CHK({o_power_down_select, o_output_phase_invert, o_bit_clock_polarity,
            o_frame_clock_polarity, o_framing_format, o_input_word_length},
            fmt_m)
        `CHK({o_zero_output_force_high, o_deemphasis_select,
            o_bitstream_comp_filter_select, o_oversampling_filter_select},
            flt_m)
        `CHK({o_filter_bypass_eight_times, o_rate_band_select,
            o_clock_ratio_select, o_operating_mode_select}, mode_m)
        `CHK(o_word_length_bits, wlb(fmt_m[1:0]))
        `CHK(o_frame_clock_invert, fmt_m[4] & (fmt_m[3:2] != 2'h3))
        `CHK(o_dsp_variant_b, fmt_m[4] & (fmt_m[3:2] == 2'h3))
    endtask : check
    task automatic rst;
        i_resetn = 1'b0;
        repeat (4) @(negedge i_clk);
        i_resetn = 1'b1;
        repeat (2) @(negedge i_clk);
        defaults();
    endtask : rst
    task final_report;
        $display("fails %0d compares %0d", fails, compares);
        if (fails == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    always @(posedge i_clk) if (o_soft_reset === 1'b1) pulses++;
    always @(negedge i_clk)
    begin
        zs = lfsr(zs);
        i_zero_detect_raw <= zs[0] & zs[1];
    end
    initial
    begin
        i_software_mode = 1'b1;
        i_rate_band_pin = 2'h0;
        i_zero_detect_raw = 1'b0;
        fails = 0;
        compares = 0;
        pulses = 0;
        rnd = 8'h23;
        zs = 8'h23;
        rst();
        check();
        for (int c = 0; c < 8; c++)
        begin
            d8 = {c[0], c[1:0], c[1:0], c[2:0]};
            wr({8'h00, 7'h06, 1'b0, d8}, 16);
            wr({8'h00, 7'h07, 1'b1, legal({c[0], c[1:0], c[2:0], c[1:0]})}, 16);
            check();
        end
        for (int k = 0; k < 30; k++)
        begin
            rnd = lfsr(rnd);
            d8 = (k % 3 == 2) ? legal(rnd) : rnd;
            rnd = lfsr(rnd);
            wr({8'h00, 7'(5 + k % 3), rnd[0], d8}, 16);
            check();
        end
        wr({8'h00, 7'h08, 9'h1ff}, 16);
        wr({8'h00, 7'h04, 9'h0ff}, 16);
        wr({8'h00, 7'h05, 9'h1ff}, 15);
        check();
        wr({4'hf, 4'h0, 7'h05, 9'h03c}, 20);
        check();
        pulses = 0;
        wr({8'h00, 7'h09, 9'h155}, 16);
        check();
        `CHK(pulses, 1)
        wr({8'h00, 7'h07, 9'h0b8}, 16);
        i_software_mode = 1'b0;
        for (int p = 0; p < 3; p++)
        begin
            i_rate_band_pin = 2'(p);
            repeat (5) @(negedge i_clk);
            `CHK(o_rate_band_effective, 2'(p))
        end
        i_software_mode = 1'b1;
        repeat (5) @(negedge i_clk);
        `CHK(o_rate_band_effective, 2'h1)
        wr({8'h00, 7'h05, 9'h0ff}, 16);
        rst();
        check();
        final_report();
    end
endmodule : test_dff_regs
`default_nettype wire

// ---- include/dff_cfg.svh ----
// constants for the converter format, filter and mode register bank
`ifndef DFF_CFG_SVH
`define DFF_CFG_SVH
// serial control word
`define DFF_ADDR_W 7
`define DFF_DATA_W 9
`define DFF_FRAME_BITS 5'h10
`define DFF_CNT_W 5
// register addresses
`define DFF_ADDR_FORMAT 7'h05
`define DFF_ADDR_FILTER 7'h06
`define DFF_ADDR_MODE1 7'h07
`define DFF_ADDR_SOFT_RESET 7'h09
// reset values
`define DFF_RST_FORMAT 8'h0a
`define DFF_RST_FILTER 8'h00
`define DFF_RST_MODE1 8'h00
// format register fields
`define DFF_IWL_MSB 1
`define DFF_IWL_LSB 0
`define DFF_FMT_MSB 3
`define DFF_FMT_LSB 2
`define DFF_LRP_BIT 4
`define DFF_BCP_BIT 5
`define DFF_REV_BIT 6
`define DFF_POWER_DOWN_SELECT_BIT 7
// filter register fields
`define DFF_FIR_MSB 2
`define DFF_FIR_LSB 0
`define DFF_CFILT_MSB 4
`define DFF_CFILT_LSB 3
`define DFF_DEEMPHASIS_SELECT_MSB 6
`define DFF_DEEMPHASIS_SELECT_LSB 5
`define DFF_ZHI_BIT 7
// mode register fields
`define DFF_MODE_MSB 1
`define DFF_MODE_LSB 0
`define DFF_RATIO_MSB 4
`define DFF_RATIO_LSB 2
`define DFF_BAND_MSB 6
`define DFF_BAND_LSB 5
`define DFF_BYPASS_BIT 7
// decoded values
`define DFF_WL_16 6'h10
`define DFF_WL_20 6'h14
`define DFF_WL_24 6'h18
`define DFF_WL_32 6'h20
`define DFF_RATIO_128 10'h080
`define DFF_RATIO_192 10'h0c0
`define DFF_RATIO_256 10'h100
`define DFF_RATIO_384 10'h180
`define DFF_RATIO_512 10'h200
`define DFF_RATIO_768 10'h300
`define DFF_RATIO_NONE 10'h000
`define DFF_DE_32K 16'h7d00
`define DFF_DE_44K1 16'hac44
`define DFF_DE_48K 16'hbb80
`define DFF_DE_OFF 16'h0000
`define DFF_FIR_MAX 3'h4
`define DFF_ONE3 3'h1
`endif

// ---- include/dff_pkg.sv ----
// types for the converter format, filter and mode register bank
`default_nettype none
package dff_pkg;
    typedef enum logic [1:0] {
        DFF_WL16 = 2'h0,
        DFF_WL20 = 2'h1,
        DFF_WL24 = 2'h2,
        DFF_WL32 = 2'h3
    } dff_wl_t;
    typedef enum logic [1:0] {
        DFF_FMT_RIGHT = 2'h0,
        DFF_FMT_LEFT = 2'h1,
        DFF_FMT_I2S = 2'h2,
        DFF_FMT_DSP = 2'h3
    } dff_fmt_t;
    typedef enum logic [1:0] {
        DFF_MODE_PCM = 2'h0,
        DFF_MODE_DIRECT = 2'h1,
        DFF_MODE_CONV = 2'h2,
        DFF_MODE_UNUSED = 2'h3
    } dff_mode_t;
    typedef enum logic [1:0] {
        DFF_BAND_LOW = 2'h0,
        DFF_BAND_MED = 2'h1,
        DFF_BAND_HIGH = 2'h2,
        DFF_BAND_UNUSED = 2'h3
    } dff_band_t;
    typedef enum logic [1:0] {
        DFF_DE_OFF = 2'h0,
        DFF_DE_32 = 2'h1,
        DFF_DE_44 = 2'h2,
        DFF_DE_48 = 2'h3
    } dff_deemphasis_select_t;
endpackage : dff_pkg
`default_nettype wire

// ---- include/dff_wr_if.sv ----
// register write carrier from serial receiver to register bank
`timescale 1ns/1ps
`default_nettype none
`include "dff_cfg.svh"
interface dff_wr_if;
    logic wr_en;
    logic [`DFF_ADDR_W-1:0] addr;
    logic [`DFF_DATA_W-1:0] data;
    modport rx (output wr_en, output addr, output data);
    modport bank (input wr_en, input addr, input data);
endinterface : dff_wr_if
`default_nettype wire

// ---- src/dff_regs.sv ----
// format, filter and mode register bank with decoded controls
`timescale 1ns/1ps
`default_nettype none
`include "dff_cfg.svh"
module dff_regs
    import dff_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // serial control pins
    input wire logic i_ctrl_csb,
    input wire logic i_ctrl_sclk,
    input wire logic i_ctrl_sdin,
    // hardware control pins
    input wire logic i_software_mode,
    input wire logic [1:0] i_rate_band_pin,
    // zero detection from datapath
    input wire logic i_zero_detect_raw,
    // format controls
    output logic [1:0] o_input_word_length,
    output logic [5:0] o_word_length_bits,
    output logic [1:0] o_framing_format,
    output logic o_frame_clock_polarity,
    output logic o_frame_clock_invert,
    output logic o_dsp_variant_b,
    output logic o_bit_clock_polarity,
    output logic o_output_phase_invert,
    output logic o_power_down_select,
    // filter controls
    output logic [2:0] o_oversampling_filter_select,
    output logic [2:0] o_oversampling_response,
    output logic [1:0] o_bitstream_comp_filter_select,
    output logic [2:0] o_bitstream_comp_response,
    output logic [1:0] o_deemphasis_select,
    output logic o_deemphasis_enable,
    output logic [15:0] o_deemphasis_rate_hz,
    output logic o_zero_output_force_high,
    output logic o_zero_detect_output,
    // mode controls
    output logic [1:0] o_operating_mode_select,
    output logic o_mode_pcm,
    output logic o_mode_bitstream_direct,
    output logic o_mode_bitstream_converted,
    output logic [2:0] o_clock_ratio_select,
    output logic o_clock_ratio_auto,
    output logic [9:0] o_clock_ratio_fs,
    output logic [1:0] o_rate_band_select,
    output logic [1:0] o_rate_band_effective,
    output logic o_filter_bypass_eight_times,
    // device-wide reset request
    output logic o_soft_reset
);
    ////////////////////////////////////////////////////////////////
    // pin synchronisers and serial receiver
    logic ctrl_csb_s;
    logic ctrl_sclk_s;
    logic ctrl_sdin_s;
    logic sw_mode_s;
    logic [1:0] band_pin_s;
    dff_wr_if wr_bus ();

    dff_sync #(
        .W(6),
        .RST(6'h01)
    ) u_sync (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_d({i_rate_band_pin, i_software_mode,
              i_ctrl_sdin, i_ctrl_sclk, i_ctrl_csb}),
        .o_q({band_pin_s, sw_mode_s, ctrl_sdin_s, ctrl_sclk_s,
              ctrl_csb_s})
    );

    dff_serial_rx u_rx (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_csb(ctrl_csb_s),
        .i_sclk(ctrl_sclk_s),
        .i_sdin(ctrl_sdin_s),
        .wr(wr_bus.rx)
    );

    ////////////////////////////////////////////////////////////////
    // address decode; data bit 8 is not stored
    logic [7:0] format_q;
    logic [7:0] format_d;
    logic [7:0] filter_q;
    logic [7:0] filter_d;
    logic [7:0] mode1_q;
    logic [7:0] mode1_d;
    logic soft_reset_q;
    wire [7:0] wr_byte = wr_bus.data[7:0];
    wire wr_format = wr_bus.wr_en & (wr_bus.addr == `DFF_ADDR_FORMAT);
    wire wr_filter = wr_bus.wr_en & (wr_bus.addr == `DFF_ADDR_FILTER);
    wire wr_mode1 = wr_bus.wr_en & (wr_bus.addr == `DFF_ADDR_MODE1);
    wire wr_reset = wr_bus.wr_en
        & (wr_bus.addr == `DFF_ADDR_SOFT_RESET);

    assign format_d = wr_reset ? `DFF_RST_FORMAT
        : wr_format ? wr_byte : format_q;
    assign filter_d = wr_reset ? `DFF_RST_FILTER
        : wr_filter ? wr_byte : filter_q;
    assign mode1_d = wr_reset ? `DFF_RST_MODE1
        : wr_mode1 ? wr_byte : mode1_q;

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            format_q <= `DFF_RST_FORMAT;
            filter_q <= `DFF_RST_FILTER;
            mode1_q <= `DFF_RST_MODE1;
            soft_reset_q <= 1'b0;
        end
        else
        begin
            format_q <= format_d;
            filter_q <= filter_d;
            mode1_q <= mode1_d;
            soft_reset_q <= wr_reset;
        end
    end

    ////////////////////////////////////////////////////////////////
    // format register decode
    wire dff_wl_t wl_w =
        dff_wl_t'(format_q[`DFF_IWL_MSB:`DFF_IWL_LSB]);
    wire dff_fmt_t fmt_w =
        dff_fmt_t'(format_q[`DFF_FMT_MSB:`DFF_FMT_LSB]);
    wire lrp_w = format_q[`DFF_LRP_BIT];
    wire is_dsp_w = (fmt_w == DFF_FMT_DSP);
    wire [5:0] wl_bits_w =
        (wl_w == DFF_WL16) ? `DFF_WL_16 :
        (wl_w == DFF_WL20) ? `DFF_WL_20 :
        (wl_w == DFF_WL24) ? `DFF_WL_24 : `DFF_WL_32;
    wire lr_inv_w = lrp_w & ~is_dsp_w;
    wire dsp_b_w = lrp_w & is_dsp_w;

    ////////////////////////////////////////////////////////////////
    // filter register decode
    wire [2:0] fir_w = filter_q[`DFF_FIR_MSB:`DFF_FIR_LSB];
    wire [1:0] cfilt_w = filter_q[`DFF_CFILT_MSB:`DFF_CFILT_LSB];
    wire dff_deemphasis_select_t de_w =
        dff_deemphasis_select_t'(filter_q[`DFF_DEEMPHASIS_SELECT_MSB:`DFF_DEEMPHASIS_SELECT_LSB]);
    wire zhi_w = filter_q[`DFF_ZHI_BIT];
    // response numbers from one; illegal filter codes give zero
    wire [2:0] fir_resp_w = (fir_w > `DFF_FIR_MAX) ? 3'h0
        : fir_w + `DFF_ONE3;
    wire [2:0] cfilt_resp_w = {1'b0, cfilt_w} + `DFF_ONE3;
    wire [15:0] de_rate_w =
        (de_w == DFF_DE_32) ? `DFF_DE_32K :
        (de_w == DFF_DE_44) ? `DFF_DE_44K1 :
        (de_w == DFF_DE_48) ? `DFF_DE_48K : `DFF_DE_OFF;
    wire zero_w = zhi_w | i_zero_detect_raw;

    ////////////////////////////////////////////////////////////////
    // mode register decode
    wire dff_mode_t mode_w =
        dff_mode_t'(mode1_q[`DFF_MODE_MSB:`DFF_MODE_LSB]);
    wire [2:0] ratio_w = mode1_q[`DFF_RATIO_MSB:`DFF_RATIO_LSB];
    wire [1:0] band_reg_w = mode1_q[`DFF_BAND_MSB:`DFF_BAND_LSB];
    // unused codes decode to no mode and no fixed ratio
    wire [9:0] ratio_fs_w =
        (ratio_w == 3'h1) ? `DFF_RATIO_128 :
        (ratio_w == 3'h2) ? `DFF_RATIO_192 :
        (ratio_w == 3'h3) ? `DFF_RATIO_256 :
        (ratio_w == 3'h4) ? `DFF_RATIO_384 :
        (ratio_w == 3'h5) ? `DFF_RATIO_512 :
        (ratio_w == 3'h6) ? `DFF_RATIO_768 : `DFF_RATIO_NONE;
    wire ratio_auto_w = (ratio_w == 3'h0);
    wire [1:0] band_eff_w = sw_mode_s ? band_reg_w
        : band_pin_s;

    ////////////////////////////////////////////////////////////////
    // registered control outputs: format
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_word_length_bits <= `DFF_WL_24;
            o_frame_clock_invert <= 1'b0;
            o_dsp_variant_b <= 1'b0;
        end
        else
        begin
            o_word_length_bits <= wl_bits_w;
            o_frame_clock_invert <= lr_inv_w;
            o_dsp_variant_b <= dsp_b_w;
        end
    end

    // registered control outputs: filter
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_oversampling_response <= `DFF_ONE3;
            o_bitstream_comp_response <= `DFF_ONE3;
            o_deemphasis_enable <= 1'b0;
            o_deemphasis_rate_hz <= `DFF_DE_OFF;
            o_zero_detect_output <= 1'b0;
        end
        else
        begin
            o_oversampling_response <= fir_resp_w;
            o_bitstream_comp_response <= cfilt_resp_w;
            o_deemphasis_enable <= (de_w != DFF_DE_OFF);
            o_deemphasis_rate_hz <= de_rate_w;
            o_zero_detect_output <= zero_w;
        end
    end

    // registered control outputs: mode
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_mode_pcm <= 1'b1;
            o_mode_bitstream_direct <= 1'b0;
            o_mode_bitstream_converted <= 1'b0;
            o_clock_ratio_auto <= 1'b1;
            o_clock_ratio_fs <= `DFF_RATIO_NONE;
            o_rate_band_effective <= 2'h0;
        end
        else
        begin
            o_mode_pcm <= (mode_w == DFF_MODE_PCM);
            o_mode_bitstream_direct <= (mode_w == DFF_MODE_DIRECT);
            o_mode_bitstream_converted <= (mode_w == DFF_MODE_CONV);
            o_clock_ratio_auto <= ratio_auto_w;
            o_clock_ratio_fs <= ratio_fs_w;
            o_rate_band_effective <= band_eff_w;
        end
    end

    ////////////////////////////////////////////////////////////////
    // raw fields straight from the register flip-flops
    assign o_input_word_length =
        format_q[`DFF_IWL_MSB:`DFF_IWL_LSB];
    assign o_framing_format =
        format_q[`DFF_FMT_MSB:`DFF_FMT_LSB];
    assign o_frame_clock_polarity = format_q[`DFF_LRP_BIT];
    assign o_bit_clock_polarity = format_q[`DFF_BCP_BIT];
    assign o_output_phase_invert = format_q[`DFF_REV_BIT];
    assign o_power_down_select = format_q[`DFF_POWER_DOWN_SELECT_BIT];
    assign o_oversampling_filter_select = fir_w;
    assign o_bitstream_comp_filter_select = cfilt_w;
    assign o_deemphasis_select =
        filter_q[`DFF_DEEMPHASIS_SELECT_MSB:`DFF_DEEMPHASIS_SELECT_LSB];
    assign o_zero_output_force_high = zhi_w;
    assign o_operating_mode_select =
        mode1_q[`DFF_MODE_MSB:`DFF_MODE_LSB];
    assign o_clock_ratio_select = ratio_w;
    assign o_rate_band_select = band_reg_w;
    assign o_filter_bypass_eight_times =
        mode1_q[`DFF_BYPASS_BIT];
    assign o_soft_reset = soft_reset_q;
endmodule : dff_regs
`default_nettype wire

// ---- src/dff_serial_rx.sv ----
// three-wire control word receiver: 7-bit address, 9-bit data
`timescale 1ns/1ps
`default_nettype none
`include "dff_cfg.svh"
module dff_serial_rx (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // synchronised control pins
    input wire logic i_csb,
    input wire logic i_sclk,
    input wire logic i_sdin,
    // decoded write
    dff_wr_if.rx wr
);
    localparam int FW = `DFF_ADDR_W + `DFF_DATA_W;
    logic sclk_q;
    logic csb_q;
    logic [FW-1:0] shift_q;
    logic [`DFF_CNT_W-1:0] cnt_q;
    logic wr_q;
    wire sclk_rise = i_sclk & ~sclk_q & ~i_csb;
    wire csb_rise = i_csb & ~csb_q;
    wire full = (cnt_q == `DFF_FRAME_BITS);

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            sclk_q <= 1'b0;
            csb_q <= 1'b1;
        end
        else
        begin
            sclk_q <= i_sclk;
            csb_q <= i_csb;
        end
    end

    // msb first; longer frames keep the last sixteen bits
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            shift_q <= '0;
            cnt_q <= '0;
        end
        else if (i_csb)
            cnt_q <= '0;
        else if (sclk_rise)
        begin
            shift_q <= {shift_q[FW-2:0], i_sdin};
            cnt_q <= full ? cnt_q : cnt_q + `DFF_CNT_W'(1);
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            wr_q <= 1'b0;
        else
            wr_q <= csb_rise & full;
    end

    assign wr.wr_en = wr_q;
    assign wr.addr = shift_q[FW-1:`DFF_DATA_W];
    assign wr.data = shift_q[`DFF_DATA_W-1:0];
endmodule : dff_serial_rx
`default_nettype wire

// ---- src/dff_sync.sv ----
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
`default_nettype none
module dff_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // pins in, synchronised out
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            meta_q <= RST;
            sync_q <= RST;
        end
        else
        begin
            meta_q <= i_d;
            sync_q <= meta_q;
        end
    end

    assign o_q = sync_q;
endmodule : dff_sync
`default_nettype wire
